// ==== rtl/uyf_consts.svh ====
// Register map, field positions, reset values and timing counts
// Operation
// - Receive flags: error 7, busy 5, idle 4, overflow 3, full 2, stop 1, empty 0
// - Bit 6 of receive and transmit flag registers always reads zero.
// - Transmit flags: busy 5, idle 4, overflow 3, full 2, space 1, empty 0
// - Transmit flag bit 7 is a power-on indicator set by every power-on reset.
// - Power-on indicator stays set until the host writes zero to it.
// - Power-on indicator never affects the interrupt output.
// - Config bit 7 selects single-ended reception; zero differential reads one.
// - Single-ended reception leaves the transmitter unchanged.
// - Single-ended selection resets to zero, giving differential reception.
// - Baud field 6:5: codes 00 and 01 500 kbps, 10 1 Mbps, 11 2 Mbps.
// - Baud field resets to code 11, 2 Mbps.
// - Config bits 4:0 are plain host storage, reset zero, no function.
// - Each receive flag has a matching enable bit; enables reset to zero.
`ifndef UYF_CONSTS_SVH
`define UYF_CONSTS_SVH

// ----------------------------------------------------------------
// Register addresses (write even, read odd)
// ----------------------------------------------------------------
`define UYF_ADDR_RX_EN_WR 8'h04
`define UYF_ADDR_RX_EN_RD 8'h05
`define UYF_ADDR_TX_EN_WR 8'h06
`define UYF_ADDR_TX_EN_RD 8'h07
`define UYF_ADDR_RX_FLAG_WR 8'h08
`define UYF_ADDR_RX_FLAG_RD 8'h09
`define UYF_ADDR_TX_FLAG_WR 8'h0A
`define UYF_ADDR_TX_FLAG_RD 8'h0B
`define UYF_ADDR_CFG1_WR 8'h0C
`define UYF_ADDR_CFG1_RD 8'h0D

// ----------------------------------------------------------------
// Field layouts
// ----------------------------------------------------------------
`define UYF_RX_FLAG_MASK 8'hBF
`define UYF_TX_EVENT_MASK 8'h3F
`define UYF_TX_FLAG_MASK 8'hBF
`define UYF_CFG_STORE_HI 4
`define UYF_RX_EN_MASK 8'hBF
`define UYF_TX_EN_MASK 8'h3F
`define UYF_POR_BIT 7
`define UYF_CFG_SE_BIT 7
`define UYF_CFG_BAUD_HI 6
`define UYF_CFG_BAUD_LO 5
`define UYF_BAUD_1M 2'h2
`define UYF_BAUD_2M 2'h3

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define UYF_RX_FLAG_RST 8'h00
`define UYF_TX_FLAG_RST 8'h80
`define UYF_EN_RST 8'h00
`define UYF_CFG1_RST 8'h60

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define UYF_CLK_MHZ 125
`define UYF_BIT_NS_500K 2000
`define UYF_BIT_NS_1M 1000
`define UYF_BIT_NS_2M 500
`define UYF_BIT_CYC_500K (`UYF_BIT_NS_500K * `UYF_CLK_MHZ / 1000)
`define UYF_BIT_CYC_1M (`UYF_BIT_NS_1M * `UYF_CLK_MHZ / 1000)
`define UYF_BIT_CYC_2M (`UYF_BIT_NS_2M * `UYF_CLK_MHZ / 1000)

`endif

// ==== rtl/uyf_pkg.sv ====
// Types for the event flag and link configuration block
package uyf_pkg;

    typedef enum logic [1:0] {
        LINK_IDLE,
        LINK_ADDR,
        LINK_LOAD,
        LINK_DATA
    } uyf_link_state_type;

    typedef struct packed {
        logic csMeta;
        logic csSync;
        logic sclkMeta;
        logic sclkSync;
        logic sclkPrev;
        logic dinMeta;
        logic dinSync;
        uyf_link_state_type state;
        logic [2:0] bitCount;
        logic [7:0] shift;
        logic [7:0] addr;
        logic [7:0] outShift;
        logic dout;
        logic wrStb;
        logic [7:0] wrAddr;
        logic [7:0] wrData;
    } uyf_link_type;

    typedef struct packed {
        logic [7:0] rxFlag;
        logic [7:0] txFlag;
        logic [7:0] rxEnable;
        logic [7:0] txEnable;
        logic [7:0] config1;
        logic [7:0] rxStatusPrev;
        logic [5:0] txStatusPrev;
        logic intN;
        logic posMeta;
        logic posSync;
        logic negMeta;
        logic negSync;
        logic rxBit;
        logic txLinePos;
        logic txLineNeg;
        logic [7:0] baudCount;
        logic bitTick;
    } uyf_regs_type;

endpackage

// ==== rtl/uyf_serial_port.sv ====
// Serial register port: samples the host clock and shifts bytes
`timescale 1ns/1ps
`default_nettype none
`include "uyf_consts.svh"

module uyf_serial_port (
    input wire logic clk_sys,
    input wire logic rstn,
    input wire logic csN,
    input wire logic sclk,
    input wire logic din,
    input wire logic [7:0] readData,
    output logic dout,
    output logic [7:0] accessAddr,
    output logic wrStb,
    output logic [7:0] wrAddr,
    output logic [7:0] wrData
);

    uyf_pkg::uyf_link_type st;
    uyf_pkg::uyf_link_type next_st;

    logic sclkRise;
    logic sclkFall;
    logic [7:0] shifted;

    always_comb begin
        next_st = st;
        next_st.csMeta = csN;
        next_st.csSync = st.csMeta;
        next_st.sclkMeta = sclk;
        next_st.sclkSync = st.sclkMeta;
        next_st.sclkPrev = st.sclkSync;
        next_st.dinMeta = din;
        next_st.dinSync = st.dinMeta;
        next_st.wrStb = 1'b0;
        sclkRise = st.sclkSync & ~st.sclkPrev;
        sclkFall = ~st.sclkSync & st.sclkPrev;
        shifted = {st.shift[6:0], st.dinSync};
        if (st.csSync) begin
            next_st.state = uyf_pkg::LINK_IDLE;
            next_st.dout = 1'b0;
        end else begin
            case (st.state)
                uyf_pkg::LINK_IDLE: begin
                    next_st.state = uyf_pkg::LINK_ADDR;
                    next_st.bitCount = 3'h0;
                end
                uyf_pkg::LINK_ADDR: begin
                    if (sclkRise) begin
                        next_st.shift = shifted;
                        next_st.bitCount = st.bitCount + 3'h1;
                        if (st.bitCount == 3'h7) begin
                            next_st.addr = shifted;
                            next_st.state = uyf_pkg::LINK_LOAD;
                        end
                    end
                end
                uyf_pkg::LINK_LOAD: begin
                    // Odd address: present read data before next rise
                    next_st.outShift = st.addr[0] ? readData : 8'h00;
                    next_st.dout = st.addr[0] & readData[7];
                    next_st.state = uyf_pkg::LINK_DATA;
                end
                uyf_pkg::LINK_DATA: begin
                    if (sclkRise) begin
                        next_st.shift = shifted;
                        next_st.bitCount = st.bitCount + 3'h1;
                        if (st.bitCount == 3'h7) begin
                            next_st.wrStb = ~st.addr[0];
                            next_st.wrAddr = st.addr;
                            next_st.wrData = shifted;
                        end
                    end else if (sclkFall && st.bitCount != 3'h0) begin
                        next_st.outShift = {st.outShift[6:0], 1'b0};
                        next_st.dout = st.outShift[6];
                    end
                end
                default: begin
                    next_st.state = uyf_pkg::LINK_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            st <= '0;
            st.csMeta <= 1'b1;
            st.csSync <= 1'b1;
            st.state <= uyf_pkg::LINK_IDLE;
        end else begin
            st <= next_st;
        end
    end

    assign dout = st.dout;
    assign accessAddr = st.addr;
    assign wrStb = st.wrStb;
    assign wrAddr = st.wrAddr;
    assign wrData = st.wrData;

endmodule // uyf_serial_port

`default_nettype wire

// ==== rtl/uyf_event_flags.sv ====
// Event flags, interrupt enables, link configuration and interrupt
`timescale 1ns/1ps
`default_nettype none
`include "uyf_consts.svh"

module uyf_event_flags (
    input wire logic clk_sys,
    input wire logic rstn,
    input wire logic csN,
    input wire logic sclk,
    input wire logic din,
    output logic dout,
    output logic intN,
    input wire logic [7:0] rxStatus,
    input wire logic [5:0] txStatus,
    input wire logic receive_line_pos,
    input wire logic receive_line_neg,
    output logic rxBit,
    input wire logic txBit,
    output logic txLinePos,
    output logic txLineNeg,
    output logic singleEnded,
    output logic [1:0] baudSel,
    output logic bitTick,
    output logic [4:0] hostStore
);

    uyf_pkg::uyf_regs_type st;
    uyf_pkg::uyf_regs_type next_st;

    logic [7:0] accessAddr;
    logic wrStb;
    logic [7:0] wrAddr;
    logic [7:0] wrData;
    logic [7:0] readData;
    logic [7:0] rxRise;
    logic [5:0] txRise;
    logic [7:0] bitCycles;

    // ----------------------------------------------------------------
    // Serial register port
    // ----------------------------------------------------------------
    uyf_serial_port port (
        .clk_sys(clk_sys),
        .rstn(rstn),
        .csN(csN),
        .sclk(sclk),
        .din(din),
        .readData(readData),
        .dout(dout),
        .accessAddr(accessAddr),
        .wrStb(wrStb),
        .wrAddr(wrAddr),
        .wrData(wrData)
    );

    // ----------------------------------------------------------------
    // Read mux
    // ----------------------------------------------------------------
    always_comb begin
        case (accessAddr)
            `UYF_ADDR_RX_EN_RD: readData = st.rxEnable;
            `UYF_ADDR_TX_EN_RD: readData = st.txEnable;
            `UYF_ADDR_RX_FLAG_RD: begin
                readData = st.rxFlag & `UYF_RX_FLAG_MASK;
            end
            `UYF_ADDR_TX_FLAG_RD: begin
                readData = st.txFlag & `UYF_TX_FLAG_MASK;
            end
            `UYF_ADDR_CFG1_RD: readData = st.config1;
            default: readData = 8'h00;
        endcase
    end

    // ----------------------------------------------------------------
    // Bit rate cycle count
    // ----------------------------------------------------------------
    always_comb begin
        case (st.config1[`UYF_CFG_BAUD_HI:`UYF_CFG_BAUD_LO])
            `UYF_BAUD_2M: bitCycles = 8'(`UYF_BIT_CYC_2M);
            `UYF_BAUD_1M: bitCycles = 8'(`UYF_BIT_CYC_1M);
            default: bitCycles = 8'(`UYF_BIT_CYC_500K);
        endcase
    end

    // ----------------------------------------------------------------
    // Next state
    // ----------------------------------------------------------------
    always_comb begin
        next_st = st;
        next_st.rxStatusPrev = rxStatus;
        next_st.txStatusPrev = txStatus;
        rxRise = rxStatus & ~st.rxStatusPrev & `UYF_RX_FLAG_MASK;
        txRise = txStatus & ~st.txStatusPrev;

        // Write zero clears, write one keeps; a new event wins
        if (wrStb && wrAddr == `UYF_ADDR_RX_FLAG_WR) begin
            next_st.rxFlag = (st.rxFlag & wrData) | rxRise;
        end else begin
            next_st.rxFlag = st.rxFlag | rxRise;
        end
        if (wrStb && wrAddr == `UYF_ADDR_TX_FLAG_WR) begin
            next_st.txFlag = {st.txFlag[7] & wrData[7], 1'b0,
                (st.txFlag[5:0] & wrData[5:0]) | txRise};
        end else begin
            next_st.txFlag = {st.txFlag[7], 1'b0,
                st.txFlag[5:0] | txRise};
        end
        if (wrStb && wrAddr == `UYF_ADDR_RX_EN_WR) begin
            next_st.rxEnable = wrData & `UYF_RX_EN_MASK;
        end
        if (wrStb && wrAddr == `UYF_ADDR_TX_EN_WR) begin
            next_st.txEnable = wrData & `UYF_TX_EN_MASK;
        end
        if (wrStb && wrAddr == `UYF_ADDR_CFG1_WR) begin
            next_st.config1 = wrData;
        end

        // Power-on bit left out of the interrupt term
        next_st.intN = ~(|(st.rxFlag & st.rxEnable)
            | |(st.txFlag[5:0] & st.txEnable[5:0]));

        // Receive slicer
        next_st.posMeta = receive_line_pos;
        next_st.posSync = st.posMeta;
        next_st.negMeta = receive_line_neg;
        next_st.negSync = st.negMeta;
        if (st.config1[`UYF_CFG_SE_BIT]) begin
            // Threshold shifted negative: equal inputs read as one
            next_st.rxBit = st.posSync | ~st.negSync;
        end else begin
            next_st.rxBit = st.posSync & ~st.negSync;
        end

        // Transmitter independent of reception mode
        next_st.txLinePos = txBit;
        next_st.txLineNeg = ~txBit;

        // Bit period tick
        if (st.baudCount >= bitCycles - 8'h01) begin
            next_st.baudCount = 8'h00;
            next_st.bitTick = 1'b1;
        end else begin
            next_st.baudCount = st.baudCount + 8'h01;
            next_st.bitTick = 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // State register
    // ----------------------------------------------------------------
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            st <= '0;
            st.rxFlag <= `UYF_RX_FLAG_RST;
            st.txFlag <= `UYF_TX_FLAG_RST;
            st.rxEnable <= `UYF_EN_RST;
            st.txEnable <= `UYF_EN_RST;
            st.config1 <= `UYF_CFG1_RST;
            st.intN <= 1'b1;
            st.txLineNeg <= 1'b1;
        end else begin
            st <= next_st;
        end
    end

    // ----------------------------------------------------------------
    // Outputs
    // ----------------------------------------------------------------
    assign intN = st.intN;
    assign rxBit = st.rxBit;
    assign txLinePos = st.txLinePos;
    assign txLineNeg = st.txLineNeg;
    assign singleEnded = st.config1[`UYF_CFG_SE_BIT];
    assign baudSel = st.config1[`UYF_CFG_BAUD_HI:`UYF_CFG_BAUD_LO];
    assign bitTick = st.bitTick;
    assign hostStore = st.config1[`UYF_CFG_STORE_HI:0];

endmodule // uyf_event_flags

`default_nettype wire

// ==== testbench/uyf_event_flags_props.sv ====
// Port checker for the event flag block
`timescale 1ns/1ps
`default_nettype none
module uyf_event_flags_chk (
    input wire logic clk_sys,
    input wire logic rstn,
    input wire logic csN,
    input wire logic intN,
    input wire logic [7:0] rxStatus,
    input wire logic [5:0] txStatus,
    input wire logic receive_line_pos,
    input wire logic receive_line_neg,
    input wire logic rxBit,
    input wire logic txBit,
    input wire logic txLinePos,
    input wire logic txLineNeg,
    input wire logic singleEnded,
    input wire logic [1:0] baudSel,
    input wire logic bitTick,
    input wire logic [4:0] hostStore
);
    logic [7:0] cnt;
    logic seen, chg, rose;
    // Cycles since tick, baud change, any status rise
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            {cnt, seen, chg, rose} <= 11'h000;
        end else begin
            cnt <= bitTick ? 8'h00 : cnt + 8'h01;
            seen <= seen | bitTick;
            chg <= $changed(baudSel) | (chg & !bitTick);
            rose <= rose | (|(rxStatus & ~$past(rxStatus) & 8'hBF))
                | (|(txStatus & ~$past(txStatus)));
        end
    end
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!rstn);
    AST_RESET_CFG: assert property (
        $rose(rstn) |-> !singleEnded && baudSel == 2'h3 && hostStore == 5'h00)
        else $error("config outputs wrong after reset");
    AST_SLICE: assert property (
        ($stable(receive_line_pos) && $stable(receive_line_neg)
        && $stable(singleEnded))[*5] |-> rxBit == (singleEnded ?
        (receive_line_pos | !receive_line_neg)
        : (receive_line_pos & !receive_line_neg)))
        else $error("sliced bit wrong");
    AST_TX_SAME: assert property (
        singleEnded |=> txLinePos == $past(txBit)
        && txLineNeg == !$past(txBit))
        else $error("transmit lines differ in single-ended mode");
    AST_TICK_PULSE: assert property (
        bitTick |=> !bitTick)
        else $error("bit tick longer than one cycle");
    AST_TICK_PERIOD: assert property (
        bitTick && seen && !chg && $stable(baudSel)
        |-> cnt == (baudSel == 2'h3 ? 8'h3D
        : baudSel == 2'h2 ? 8'h7C : 8'hF9))
        else $error("bit period wrong");
    AST_POR_NO_INT: assert property (
        !rose |-> intN)
        else $error("interrupt without any status rise");
    AST_INT_HOLD: assert property (
        !intN && csN && $past(csN, 4) |=> !intN)
        else $error("interrupt released without host access");
    AST_CFG_HOLD: assert property (
        csN [*8] |-> $stable({singleEnded, baudSel, hostStore}))
        else $error("config changed outside a frame");
endmodule // uyf_event_flags_chk
bind uyf_event_flags uyf_event_flags_chk uyf_event_flags_chk_inst (.*);
`default_nettype wire

// ==== testbench/uyf_host_model.sv ====
// Host model driving the serial register port
`timescale 1ns/1ps
`default_nettype none
module uyf_host_model (
    input wire logic clk_sys,
    output logic csN,
    output logic sclk,
    output logic din,
    input wire logic dout
);
    initial begin
        csN = 1'b1;
        sclk = 1'b0;
        din = 1'b0;
    end
    // Address byte then data byte, MSB first, sclk idle low
    task automatic xfer(input logic [7:0] a, input logic [7:0] d,
        output logic [7:0] r);
        logic [15:0] s;
        s = {a, d};
        r = 8'h00;
        @(posedge clk_sys) #1 csN = 1'b0;
        for (int i = 15; i >= 0; i--) begin
            din = s[i];
            repeat (10) @(posedge clk_sys);
            #1 sclk = 1'b1;
            if (i < 8) r = {r[6:0], dout};
            repeat (10) @(posedge clk_sys);
            #1 sclk = 1'b0;
        end
        din = ~din;
        repeat (10) @(posedge clk_sys);
        #1 csN = 1'b1;
        repeat (6) @(posedge clk_sys);
    endtask
endmodule // uyf_host_model
`default_nettype wire

// ==== testbench/uyf_event_flags_tb.sv ====
// Self-checking bench for the event flag block
`timescale 1ns/1ps
`default_nettype none
module uyf_event_flags_tb;
    logic clk_sys, rstn, csN, sclk, din, dout, intN, rxBit, txBit;
    logic receive_line_pos, receive_line_neg, txLinePos, txLineNeg;
    logic singleEnded, bitTick;
    logic [7:0] rxStatus, v;
    logic [5:0] txStatus;
    logic [1:0] baudSel;
    logic [4:0] hostStore;
    int mRx, mTx, mRxEn, mTxEn, mCfg, p, n_fail, tests_run;

    uyf_event_flags uyf_event_flags_inst (.*);
    uyf_host_model uyf_host_model_inst (.*);

    initial begin
        clk_sys = 1'b0;
        forever #4 clk_sys = ~clk_sys;
    end

    task stop_test();
        $display("checks %0d mismatches %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask

    task chk(input string n, input logic [7:0] e, input logic [7:0] g);
        tests_run++;
        if (g !== e) begin
            n_fail++;
            $display("MISMATCH %s expected %h seen %h", n, e, g);
        end
    endtask

    task init_model();
        {mRx, mTx, mRxEn} = {32'h0, 32'h80, 32'h0};
        {mTxEn, mCfg} = {32'h0, 32'h60};
    endtask

    task wr(input logic [7:0] a, input logic [7:0] d);
        logic [7:0] r;
        uyf_host_model_inst.xfer(a, d, r);
        case (a)
            8'h04: mRxEn = d & 8'hBF;
            8'h06: mTxEn = d & 8'h3F;
            8'h08: mRx &= d;
            8'h0A: mTx &= d;
            8'h0C: mCfg = d;
            default: ;
        endcase
    endtask

    task rd(input logic [7:0] a, input logic [7:0] e);
        logic [7:0] r;
        uyf_host_model_inst.xfer(a, 8'h00, r);
        chk($sformatf("reg %h", a), e, r);
    endtask

    task chk_int();
        chk("intN", {7'h00, ((mRx & mRxEn) | (mTx & mTxEn)) == 0},
            {7'h00, intN});
    endtask

    task pulse(input logic [7:0] rv, input logic [5:0] tv);
        @(posedge clk_sys) #1 rxStatus = rv;
        txStatus = tv;
        mRx |= rv & 8'hBF;
        mTx |= tv;
        @(posedge clk_sys) #1 rxStatus = 8'h00;
        txStatus = 6'h00;
        repeat (3) @(posedge clk_sys);
        chk_int();
    endtask

    // Edges between two bit ticks
    task period(output int n);
        int i;
        for (i = 0; i < 600 && bitTick !== 1'b1; i++) @(posedge clk_sys) #1;
        for (n = 1; n < 600; n++) begin
            @(posedge clk_sys) #1;
            if (bitTick === 1'b1) break;
        end
        if (i >= 600 || n >= 600) begin
            n_fail++;
            stop_test();
        end
    endtask

    initial begin
        {rstn, txBit, receive_line_pos, receive_line_neg} = 4'h1;
        {rxStatus, txStatus} = 14'h0000;
        {n_fail, tests_run} = 64'h0;
        void'($urandom(84));
        init_model();
        repeat (6) @(posedge clk_sys);
        #1 rstn = 1'b1;
        repeat (6) @(posedge clk_sys);
        rd(8'h09, 8'h00);
        rd(8'h0B, 8'h80);
        rd(8'h0D, 8'h60);
        rd(8'h05, 8'h00);
        rd(8'h21, 8'h00);
        wr(8'h06, 8'hFF);
        chk_int();
        $display("test reset done");
        for (int b = 0; b < 4; b++) begin
            v = 8'($urandom);
            v[6:5] = 2'(b);
            v[7] = b[0];
            wr(8'h0C, v);
            rd(8'h0D, 8'(mCfg));
            v = {singleEnded, baudSel, hostStore};
            chk("cfg", 8'(mCfg), v);
            v = 8'(mCfg);
            period(p);
            chk("tick", b == 3 ? 8'h3E : b == 2 ? 8'h7D : 8'hFA, 8'(p));
            for (int k = 0; k < 4; k++) begin
                @(posedge clk_sys) #1 {receive_line_pos, receive_line_neg} = 2'(k);
                txBit = 1'($urandom);
                repeat (5) @(posedge clk_sys);
                #1 chk("rxBit", {7'h00, v[7]
                    ? (receive_line_pos | !receive_line_neg)
                    : (receive_line_pos & !receive_line_neg)},
                    {7'h00, rxBit});
                chk("txLine", {6'h00, txBit, !txBit},
                    {6'h00, txLinePos, txLineNeg});
            end
        end
        $display("test config done");
        pulse(8'hFF, 6'h3F);
        for (int k = 0; k < 6; k++) begin
            rd(8'h09, 8'(mRx));
            rd(8'h0B, 8'(mTx));
            wr(8'h04, 8'($urandom));
            wr(8'h06, 8'($urandom));
            chk_int();
            v = 8'($urandom);
            wr(8'h08, v);
            wr(8'h0A, v);
            chk_int();
            pulse(8'($urandom), 6'($urandom));
        end
        $display("test flags done");
        @(posedge clk_sys) #1 rstn = 1'b0;
        repeat (2) @(posedge clk_sys);
        #1 rstn = 1'b1;
        init_model();
        repeat (6) @(posedge clk_sys);
        rd(8'h0B, 8'h80);
        rd(8'h0D, 8'h60);
        wr(8'h0A, 8'h80);
        rd(8'h0B, 8'(mTx));
        wr(8'h0A, 8'h00);
        rd(8'h0B, 8'(mTx));
        $display("test rerun done");
        stop_test();
    end
endmodule // uyf_event_flags_tb
`default_nettype wire
